// file: rtl/lcm_consts.svh
// Constants for the link controller main status and data port block
`ifndef LCM_CONSTS_SVH
`define LCM_CONSTS_SVH

// Word geometry
`define LCM_W            16
`define LCM_WORD_RST     16'h0000
`define LCM_SEL_HI       3
`define LCM_SEL_LO       1
`define LCM_SEL_MAIN     3'h0
`define LCM_FIRST_AUX    1
`define LCM_LAST_WORD    5

// Main control/status word bit positions
`define LCM_B_POLL_NOW   15
`define LCM_B_POWERED_OFF_FLAG       14
`define LCM_B_TX_DIS     13
`define LCM_B_RX_DIS     12
`define LCM_B_TX_ACT     11
`define LCM_B_RX_ACT     10
`define LCM_B_IRQ_EN     9
`define LCM_B_IRQ_SUM    8
`define LCM_B_BUS_TMO    7
`define LCM_B_LOST       6
`define LCM_B_RX_OVF     5
`define LCM_B_PRIM_UPD   3
`define LCM_B_TX_UPD     2
`define LCM_B_RX_UPD     1

// Timing: clock period, master timeout, transmit poll interval
`define LCM_CLK_NS       20
`define LCM_TMO_NS       5120
`define LCM_TMO_CYCLES   (`LCM_TMO_NS / `LCM_CLK_NS)
`define LCM_TMO_LAST     9'(`LCM_TMO_CYCLES - 1)
`define LCM_TMO_ZERO     9'h000
`define LCM_TMO_ONE      9'h001
`define LCM_POLL_NS      40960
`define LCM_POLL_CYCLES  (`LCM_POLL_NS / `LCM_CLK_NS)
`define LCM_POLL_LAST    12'(`LCM_POLL_CYCLES - 1)
`define LCM_POLL_ZERO    12'h000
`define LCM_POLL_ONE     12'h001

`endif

// file: rtl/lcm_pkg.sv
// Types shared by the link controller main status and data port block
package lcm_pkg;
    typedef logic [15:0] lcm_word_t;

    typedef enum logic [1:0] {
        LCM_TMO_IDLE  = 2'b00,
        LCM_TMO_WAIT  = 2'b01,
        LCM_TMO_FAULT = 2'b10
    } lcm_tmo_t;
endpackage

// file: rtl/lcm_flag_cell.sv
// Sticky event flag: set by hardware, cleared by write-one or power-off
`timescale 1ns/10ps
`default_nettype none
module lcm_flag_cell (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic set_evt,
    input  wire logic clr_evt,
    output var  logic flag
);
    // Set wins so an event landing on the clear cycle is kept
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else if (set_evt) begin
            flag <= 1'b1; // R16
        end else if (clr_evt) begin
            flag <= 1'b0; // R16
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_flag_set_wins: assert property (set_evt |=> flag) // R16
        else $error("flag lost an event");
    chk_flag_clear: assert property (clr_evt && !set_evt |=> !flag) // R16
        else $error("flag ignored a clear");
    chk_flag_hold: assert property (!set_evt && !clr_evt |=> flag == $past(flag))
        else $error("flag changed without cause");
endmodule
`default_nettype wire

// file: rtl/lcm_main_status_port.sv
// Host data port, address select and main control/status word
// What this block does
// R1 - Data port write stores into the word picked by the select field
// R2 - Data port read returns the word picked by the select field
// R3 - Poll-now request polls the transmit ring at once; timer polls anyway
// R4 - Poll-now set by writing one only; cleared when used, at power-off or reset
// R5 - Powered-off flag read-only, set by reset or power-off; holds logic
// R6 - Transmit disable stops ring access after the current unit; read/write
// R7 - Receive disable stops ring access after the current unit; read/write
// R8 - Transmit active sets on power-on or disable clear; clears on disable, power-off or bus timeout
// R9 - With transmit active clear, the ring is untouched; host may rewrite
// R10 - Receive active follows receive disable like transmit active does
// R11 - Interrupt pin low only when enable and summary are both one
// R12 - Interrupt enable read/write; cleared and held clear while powered off
// R13 - Summary flag is the OR of the event flags; clears with them
// R14 - Bus timeout error sets after 256 cycles without ready as master
// R15 - On bus timeout release the bus and stop receiver and transmitter
// R16 - Error flags set by hardware, cleared by writing one or power-off
// R17 - Lost message flag sets when a unit is dropped for lack of buffer
// R18 - Overflow flag sets when receive FIFO is full on push while receive is active; unit dropped
// R19 - Three-bit select in the address port, read/write, reset to zero
// R20 - Receive update flag sets after a receive descriptor update
// R21 - Transmit update flag sets after a transmit descriptor update
// R22 - Primitive update flag sets after a primitive register write
`timescale 1ns/10ps
`default_nettype none
`include "lcm_consts.svh"
module lcm_main_status_port (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        bus_sel,
    input  wire logic        bus_adr,
    input  wire logic        bus_rd,
    input  wire logic        bus_wr,
    input  wire logic [15:0] bus_data_in,
    output var  logic [15:0] bus_data_out,
    output var  logic        bus_data_oe,
    input  wire logic        bus_ready,
    input  wire logic        master_addr_out,
    output logic             bus_release,
    input  wire logic        prim_power_off,
    input  wire logic        prim_power_on,
    input  wire logic        tx_desc_updated,
    input  wire logic        rx_desc_updated,
    input  wire logic        prim_reg_written,
    input  wire logic        rx_msu_no_buffer,
    input  wire logic        rx_fifo_push,
    input  wire logic        rx_fifo_full,
    input  wire logic        tx_su_busy,
    input  wire logic        rx_su_busy,
    output var  logic        tx_poll_strobe,
    output var  logic        tx_ring_active,
    output var  logic        rx_ring_active,
    output var  logic        tx_ring_disable,
    output var  logic        rx_ring_disable,
    output var  logic        powered_off,
    output logic             internal_hold,
    output var  logic        rx_unit_discard,
    output var  logic        irq_n
);
    // Pin synchronisers; stage one feeds stage two only
    logic        sel_m, adr_m, rd_m, wr_m, rdy_m;
    logic        sel_s, adr_s, rd_s, wr_s, rdy_s;
    logic [15:0] din_m, din_s;
    logic        wr_d;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {sel_m, adr_m, rd_m, wr_m, rdy_m} <= 5'h00;
            {sel_s, adr_s, rd_s, wr_s, rdy_s} <= 5'h00;
            din_m <= `LCM_WORD_RST;
            din_s <= `LCM_WORD_RST;
            wr_d  <= 1'b0;
        end else begin
            {sel_m, adr_m, rd_m, wr_m, rdy_m} <=
                {bus_sel, bus_adr, bus_rd, bus_wr, bus_ready};
            {sel_s, adr_s, rd_s, wr_s, rdy_s} <=
                {sel_m, adr_m, rd_m, wr_m, rdy_m};
            din_m <= bus_data_in;
            din_s <= din_m;
            wr_d  <= sel_s & wr_s;
        end
    end

    // One write event per host strobe; data is stable by then
    logic wr_evt, wr_addr, wr_data, wr_main;
    logic [2:0] csr_sel;
    assign wr_evt  = sel_s & wr_s & ~wr_d;
    assign wr_addr = wr_evt & adr_s;
    assign wr_data = wr_evt & ~adr_s;
    assign wr_main = wr_data & (csr_sel == `LCM_SEL_MAIN);

    // Address port select field
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            csr_sel <= `LCM_SEL_MAIN;
        end else if (wr_addr) begin
            csr_sel <= din_s[`LCM_SEL_HI:`LCM_SEL_LO]; // R19
        end
    end

    // Plain storage for the other control words
    lcm_pkg::lcm_word_t aux_word [`LCM_FIRST_AUX:`LCM_LAST_WORD];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = `LCM_FIRST_AUX; i <= `LCM_LAST_WORD; i++) begin
                aux_word[i] <= `LCM_WORD_RST;
            end
        end else begin
            for (int i = `LCM_FIRST_AUX; i <= `LCM_LAST_WORD; i++) begin
                if (wr_data && csr_sel == 3'(i)) begin
                    aux_word[i] <= din_s; // R1
                end
            end
        end
    end

    // Power state; reset enters powered-off
    logic pwr_on_evt, pwr_off_evt;
    assign pwr_on_evt  = prim_power_on & powered_off;
    assign pwr_off_evt = prim_power_off & ~powered_off;
    assign internal_hold = powered_off; // R5
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            powered_off <= 1'b1; // R5
        end else if (pwr_off_evt) begin
            powered_off <= 1'b1; // R5
        end else if (pwr_on_evt) begin
            powered_off <= 1'b0;
        end
    end

    // Ring disable bits, plain read/write
    logic tx_dis_d, rx_dis_d;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_ring_disable <= 1'b0;
            rx_ring_disable <= 1'b0;
            tx_dis_d        <= 1'b0;
            rx_dis_d        <= 1'b0;
        end else begin
            if (wr_main) begin
                tx_ring_disable <= din_s[`LCM_B_TX_DIS]; // R6
                rx_ring_disable <= din_s[`LCM_B_RX_DIS]; // R7
            end
            tx_dis_d <= tx_ring_disable;
            rx_dis_d <= rx_ring_disable;
        end
    end

    // Master timeout watch; cleared while the logic is held
    lcm_pkg::lcm_tmo_t tmo_state;
    logic [8:0]        tmo_cnt;
    logic              tmo_fault;
    assign tmo_fault   = (tmo_state == lcm_pkg::LCM_TMO_FAULT);
    assign bus_release = tmo_fault; // R15
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tmo_state <= lcm_pkg::LCM_TMO_IDLE;
            tmo_cnt   <= `LCM_TMO_ZERO;
        end else if (powered_off) begin
            tmo_state <= lcm_pkg::LCM_TMO_IDLE;
            tmo_cnt   <= `LCM_TMO_ZERO;
        end else begin
            case (tmo_state)
                lcm_pkg::LCM_TMO_IDLE: begin
                    tmo_cnt <= `LCM_TMO_ZERO;
                    if (master_addr_out) begin
                        tmo_state <= lcm_pkg::LCM_TMO_WAIT;
                    end
                end
                lcm_pkg::LCM_TMO_WAIT: begin
                    if (rdy_s) begin
                        tmo_state <= lcm_pkg::LCM_TMO_IDLE;
                    end else if (tmo_cnt == `LCM_TMO_LAST) begin
                        tmo_state <= lcm_pkg::LCM_TMO_FAULT; // R14
                    end else begin
                        tmo_cnt <= tmo_cnt + `LCM_TMO_ONE;
                    end
                end
                lcm_pkg::LCM_TMO_FAULT: begin
                    tmo_state <= lcm_pkg::LCM_TMO_IDLE;
                end
                default: begin
                    tmo_state <= lcm_pkg::LCM_TMO_IDLE;
                end
            endcase
        end
    end

    // Ring active bits; a unit in flight finishes before a disable drops the bit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_ring_active <= 1'b0;
            rx_ring_active <= 1'b0;
        end else begin
            if (pwr_off_evt || tmo_fault) begin
                tx_ring_active <= 1'b0; // R8 R15
            end else if (tx_ring_disable && !tx_su_busy) begin
                tx_ring_active <= 1'b0; // R6 R8
            end else if ((pwr_on_evt && !tx_ring_disable) ||
                         (!powered_off && tx_dis_d && !tx_ring_disable)) begin
                tx_ring_active <= 1'b1; // R8
            end
            if (pwr_off_evt || tmo_fault) begin
                rx_ring_active <= 1'b0; // R10 R15
            end else if (rx_ring_disable && !rx_su_busy) begin
                rx_ring_active <= 1'b0; // R7 R10
            end else if ((pwr_on_evt && !rx_ring_disable) ||
                         (!powered_off && rx_dis_d && !rx_ring_disable)) begin
                rx_ring_active <= 1'b1; // R10
            end
        end
    end

    // Poll-now request and the interval timer that polls without it
    logic        poll_now;
    logic [11:0] poll_cnt;
    logic        poll_due;
    // A set disable stops polling even while the last unit drains
    assign poll_due = tx_ring_active & ~tx_ring_disable &
                      (poll_now | (poll_cnt == `LCM_POLL_LAST)); // R3 R6
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            poll_now <= 1'b0;
        end else if (wr_main && din_s[`LCM_B_POLL_NOW]) begin
            poll_now <= 1'b1; // R4
        end else if ((poll_now && poll_due) || pwr_off_evt) begin
            poll_now <= 1'b0; // R4
        end
    end

    // The ring is only polled while transmit is active
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            poll_cnt       <= `LCM_POLL_ZERO;
            tx_poll_strobe <= 1'b0;
        end else begin
            tx_poll_strobe <= poll_due; // R3 R9
            if (poll_due || !tx_ring_active || tx_ring_disable) begin
                poll_cnt <= `LCM_POLL_ZERO;
            end else begin
                poll_cnt <= poll_cnt + `LCM_POLL_ONE;
            end
        end
    end

    // Event flags: write one clears, power-off clears, set wins
    logic clr_any, rx_ovf_evt;
    logic f_tmo, f_lost, f_ovf, f_rxu, f_txu, f_prim;
    assign clr_any    = pwr_off_evt;
    assign rx_ovf_evt = rx_fifo_push & rx_fifo_full & rx_ring_active;

    lcm_flag_cell u_tmo (
        .clk     (clk),
        .nrst    (nrst),
        .set_evt (tmo_fault), // R14
        .clr_evt (clr_any | (wr_main & din_s[`LCM_B_BUS_TMO])),
        .flag    (f_tmo)
    );
    lcm_flag_cell u_lost (
        .clk     (clk),
        .nrst    (nrst),
        .set_evt (rx_msu_no_buffer), // R17
        .clr_evt (clr_any | (wr_main & din_s[`LCM_B_LOST])),
        .flag    (f_lost)
    );
    lcm_flag_cell u_ovf (
        .clk     (clk),
        .nrst    (nrst),
        .set_evt (rx_ovf_evt), // R18
        .clr_evt (clr_any | (wr_main & din_s[`LCM_B_RX_OVF])),
        .flag    (f_ovf)
    );
    lcm_flag_cell u_rxu (
        .clk     (clk),
        .nrst    (nrst),
        .set_evt (rx_desc_updated), // R20
        .clr_evt (clr_any | (wr_main & din_s[`LCM_B_RX_UPD])),
        .flag    (f_rxu)
    );
    lcm_flag_cell u_txu (
        .clk     (clk),
        .nrst    (nrst),
        .set_evt (tx_desc_updated), // R21
        .clr_evt (clr_any | (wr_main & din_s[`LCM_B_TX_UPD])),
        .flag    (f_txu)
    );
    lcm_flag_cell u_prim (
        .clk     (clk),
        .nrst    (nrst),
        .set_evt (prim_reg_written), // R22
        .clr_evt (clr_any | (wr_main & din_s[`LCM_B_PRIM_UPD])),
        .flag    (f_prim)
    );

    // Dropped units are reported to the receive framer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_unit_discard <= 1'b0;
        end else begin
            rx_unit_discard <= rx_ovf_evt; // R18
        end
    end

    // Interrupt enable, forced clear while powered off
    logic irq_en, irq_sum;
    assign irq_sum = f_tmo | f_lost | f_ovf | f_rxu | f_txu | f_prim; // R13
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_en <= 1'b0;
        end else if (powered_off || pwr_off_evt) begin
            irq_en <= 1'b0; // R12
        end else if (wr_main) begin
            irq_en <= din_s[`LCM_B_IRQ_EN]; // R12
        end
    end

    // Registered pin avoids glitches while flags change together
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~(irq_en & irq_sum); // R11 R15
        end
    end

    // Read mux; select values past the last word read as zero
    lcm_pkg::lcm_word_t main_word, next_rdata;
    always_comb begin
        main_word = `LCM_WORD_RST;
        main_word[`LCM_B_POLL_NOW] = poll_now;
        main_word[`LCM_B_POWERED_OFF_FLAG]     = powered_off;
        main_word[`LCM_B_TX_DIS]   = tx_ring_disable;
        main_word[`LCM_B_RX_DIS]   = rx_ring_disable;
        main_word[`LCM_B_TX_ACT]   = tx_ring_active;
        main_word[`LCM_B_RX_ACT]   = rx_ring_active;
        main_word[`LCM_B_IRQ_EN]   = irq_en;
        main_word[`LCM_B_IRQ_SUM]  = irq_sum;
        main_word[`LCM_B_BUS_TMO]  = f_tmo;
        main_word[`LCM_B_LOST]     = f_lost;
        main_word[`LCM_B_RX_OVF]   = f_ovf;
        main_word[`LCM_B_PRIM_UPD] = f_prim;
        main_word[`LCM_B_TX_UPD]   = f_txu;
        main_word[`LCM_B_RX_UPD]   = f_rxu;
        next_rdata = `LCM_WORD_RST;
        if (adr_s) begin
            next_rdata[`LCM_SEL_HI:`LCM_SEL_LO] = csr_sel;
        end else if (csr_sel == `LCM_SEL_MAIN) begin
            next_rdata = main_word; // R2
        end else begin
            for (int i = `LCM_FIRST_AUX; i <= `LCM_LAST_WORD; i++) begin
                if (csr_sel == 3'(i)) begin
                    next_rdata = aux_word[i]; // R2
                end
            end
        end
    end

    // Data drive follows the synchronised read strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_data_out <= `LCM_WORD_RST;
            bus_data_oe  <= 1'b0;
        end else begin
            bus_data_out <= next_rdata;
            bus_data_oe  <= sel_s & rd_s;
        end
    end

    // Assertion helper: cycles spent waiting on a silent ready line
    logic [8:0] tmo_wait_cnt;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tmo_wait_cnt <= `LCM_TMO_ZERO;
        end else if (tmo_state == lcm_pkg::LCM_TMO_WAIT && !rdy_s) begin
            tmo_wait_cnt <= tmo_wait_cnt + `LCM_TMO_ONE;
        end else begin
            tmo_wait_cnt <= `LCM_TMO_ZERO;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    localparam int TMO_N = `LCM_TMO_CYCLES;

    chk_irq_pin_low: assert property (irq_en && irq_sum |=> !irq_n) // R11
        else $error("interrupt pin not low");
    chk_irq_pin_high: assert property (!irq_en |=> irq_n) // R11
        else $error("interrupt pin low while disabled");
    chk_powered_off_flag_no_enable: assert property (powered_off |=> !irq_en) // R12
        else $error("enable set while powered off");
    chk_poll_now_write: assert property ( // R4
        !poll_now && !(wr_main && din_s[`LCM_B_POLL_NOW]) |=> !poll_now)
        else $error("poll request set without write");
    chk_poll_strobe: assert property ( // R3
        poll_now && tx_ring_active && !tx_ring_disable
        |=> tx_poll_strobe ##1 (!poll_now || $past(wr_main)))
        else $error("poll request not acted upon");
    chk_no_poll_idle: assert property ( // R6 R9
        !tx_ring_active || tx_ring_disable |=> !tx_poll_strobe)
        else $error("ring polled while inactive");
    chk_tmo_fault_time: assert property ( // R14
        tmo_state == lcm_pkg::LCM_TMO_WAIT && !rdy_s && !powered_off
        && tmo_wait_cnt == 9'(TMO_N - 1) |=> tmo_fault)
        else $error("timeout not flagged in time");
    chk_tmo_release: assert property ( // R15
        tmo_fault |=> f_tmo && !tx_ring_active && !rx_ring_active)
        else $error("timeout did not stop rings");
    chk_tx_disable: assert property ( // R6
        tx_ring_disable && !tx_su_busy |=> !tx_ring_active)
        else $error("transmit ring still active");
    chk_rx_disable: assert property ( // R7
        rx_ring_disable && !rx_su_busy |=> !rx_ring_active)
        else $error("receive ring still active");
    chk_powered_off_flag_clears: assert property ( // R5
        pwr_off_evt |=> powered_off && !irq_sum && !tx_ring_active)
        else $error("power-off did not clear state");
    chk_select_write: assert property ( // R19
        wr_addr |=> csr_sel == $past(din_s[`LCM_SEL_HI:`LCM_SEL_LO]))
        else $error("select field not stored");
    chk_main_readback: assert property ( // R2
        !adr_s && csr_sel == `LCM_SEL_MAIN
        |=> bus_data_out == $past(main_word))
        else $error("main word read back wrong");

    cov_poll_now: cover property (wr_main && din_s[`LCM_B_POLL_NOW]
        ##[1:4] tx_poll_strobe);
    cov_timeout: cover property (tmo_fault ##2 !irq_n);
    cov_power_on: cover property (pwr_on_evt ##1 tx_ring_active);
    cov_overflow: cover property (rx_ovf_evt ##1 rx_unit_discard);
endmodule
`default_nettype wire

// file: testbench/lcm_host_model.sv
// Host processor model driving the slave register port
`timescale 1ns/10ps
`default_nettype none
module lcm_host_model (
    input  wire logic        clk,
    output var  logic        sel,
    output var  logic        adr,
    output var  logic        rd,
    output var  logic        wr,
    output var  logic [15:0] dout,
    input  wire logic [15:0] din,
    input  wire logic        oe
);
    int fails = 0;

    // Idle bus at time zero
    initial begin
        {sel, adr, rd, wr} = 4'h0;
        dout = 16'h0000;
    end

    // Write: pins pass two sync flops, so hold well past the take edge
    task automatic put(input logic a, input logic [15:0] d);
        @(posedge clk) #1;
        {sel, adr, wr, dout} = {1'b1, a, 1'b1, d};
        repeat (4) @(posedge clk);
        #1 {sel, wr} = 2'b00;
        dout = ~d; // Released lines must not keep the old value
        repeat (3) @(posedge clk);
    endtask

    // Read: hold until the drive enable is seen, take data at that edge
    task automatic get(input logic a, output logic [15:0] d);
        int n;
        @(posedge clk) #1;
        {sel, adr, rd} = {1'b1, a, 1'b1};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (oe !== 1'b1 && n < 8);
        if (oe !== 1'b1) fails++;
        d = din;
        #1 {sel, rd} = 2'b00;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: testbench/link_ctrl_main_status_port_test.sv
// Self-checking bench for the main status word and data port
`timescale 1ns/10ps
`default_nettype none
module link_ctrl_main_status_port_test;
    logic        clk, nrst, bus_sel, bus_adr, bus_rd, bus_wr, bus_data_oe;
    logic        bus_ready, bus_release, tx_poll_strobe, irq_n, rx_fifo_full;
    logic        internal_hold, rx_unit_discard, powered_off, tx_ring_active;
    logic        rx_ring_active, tx_ring_disable, rx_ring_disable;
    logic [15:0] bus_data_in, bus_data_out, v;
    logic [31:0] r;
    logic [7:0]  ev;
    logic        su_busy;
    int          miscompares, check_count, n, m, b;
    int          polls = 0, drops = 0;

    lcm_main_status_port dut (
        .clk, .nrst, .bus_sel, .bus_adr, .bus_rd, .bus_wr, .bus_data_in,
        .bus_data_out, .bus_data_oe, .bus_ready, .master_addr_out(ev[7]),
        .bus_release, .prim_power_off(ev[0]), .prim_power_on(ev[1]),
        .tx_desc_updated(ev[2]), .rx_desc_updated(ev[3]),
        .prim_reg_written(ev[4]), .rx_msu_no_buffer(ev[5]),
        .rx_fifo_push(ev[6]), .rx_fifo_full, .tx_su_busy(su_busy),
        .rx_su_busy(su_busy), .tx_poll_strobe, .tx_ring_active,
        .rx_ring_active, .tx_ring_disable, .rx_ring_disable, .powered_off,
        .internal_hold, .rx_unit_discard, .irq_n
    );
    lcm_host_model host (
        .clk, .sel(bus_sel), .adr(bus_adr), .rd(bus_rd), .wr(bus_wr),
        .dout(bus_data_in), .din(bus_data_out), .oe(bus_data_oe)
    );

    initial clk = 1'b0;
    always #10 clk = ~clk;
    // Count poll strobes and dropped-unit pulses; the timer adds polls too
    always @(posedge clk) if (tx_poll_strobe === 1'b1) polls <= polls + 1;
    always @(posedge clk) if (rx_unit_discard === 1'b1) drops <= drops + 1;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // Read the main word and compare with the model
    task automatic rdm;
        host.get(1'b0, v);
        chk(v, m[15:0]);
        chk(16'({powered_off, internal_hold}), 16'({m[14], m[14]}));
        chk(16'({tx_ring_disable, rx_ring_disable}), 16'(m[13:12]));
        chk(16'({tx_ring_active, rx_ring_active}), 16'(m[11:10]));
    endtask

    task automatic pulse(input int k);
        @(posedge clk) #1 ev[k] = 1'b1;
        @(posedge clk) #1 ev[k] = 1'b0;
    endtask

    // Bounded wait for the release pulse; 300 means it never came
    task automatic wait_rel;
        n = 0;
        while (bus_release !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic end_sim;
        miscompares += host.fails;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #1_500_000;
        miscompares++;
        end_sim;
    end

    initial begin
        {nrst, bus_ready, rx_fifo_full, su_busy, ev} = '0;
        miscompares = 0;
        check_count = 0;
        r = 32'hCDF9;
        repeat (8) @(posedge clk);
        #1 nrst = 1'b1;
        m = 32'h4000;
        rdm;
        host.get(1'b1, v);
        chk(v, 16'h0000);
        host.put(1'b0, 16'h0200);
        rdm;
        pulse(1);
        m = 32'h0C00;
        rdm;
        $display("reset and power-on test done");
        // Spare words with random data, then a select past the last word
        for (int s = 1; s <= 6; s++) begin
            r = lfsr(r);
            host.put(1'b1, 16'(s << 1));
            host.put(1'b0, r[15:0]);
            host.get(1'b1, v);
            chk(v, 16'(s << 1));
            host.get(1'b0, v);
            chk(v, s < 6 ? r[15:0] : 16'h0000);
        end
        host.put(1'b1, 16'h0000);
        rdm;
        $display("select test done");
        // Each event flag but the timeout: set, pin, write-zero, enable off, write-one
        #1 rx_fifo_full = 1'b1;
        for (int k = 2; k <= 6; k++) begin
            b = k == 2 ? 4 : k == 3 ? 2 : k == 4 ? 8 : k == 5 ? 64 : 32;
            host.put(1'b0, 16'h0200);
            pulse(k);
            m = 32'h0F00 | b;
            rdm;
            chk(16'(irq_n), 16'h0000);
            host.put(1'b0, 16'h0000);
            m = m & ~32'h0200;
            rdm;
            chk(16'(irq_n), 16'h0001);
            host.put(1'b0, 16'(b));
            m = 32'h0C00;
            rdm;
        end
        #1 rx_fifo_full = 1'b0;
        chk(16'(drops), 16'h0001);
        $display("flag test done");
        b = polls;
        host.put(1'b0, 16'h8000);
        chk(16'(polls > b), 16'h0001);
        rdm;
        b = polls;
        repeat (2100) @(posedge clk);
        chk(16'(polls > b), 16'h0001);
        #1 su_busy = 1'b1;
        host.put(1'b0, 16'h3000);
        b = polls;
        repeat (2100) @(posedge clk);
        chk(16'(polls - b), 16'h0000);
        m = 32'h3C00;
        rdm;
        #1 su_busy = 1'b0;
        m = 32'h3000;
        rdm;
        host.put(1'b0, 16'h0000);
        m = 32'h0C00;
        rdm;
        $display("poll and disable test done");
        // Master cycle answered in time, then one left hanging
        #1 bus_ready = 1'b1;
        pulse(7);
        wait_rel;
        chk(16'(n), 16'h012C);
        host.put(1'b0, 16'h0200);
        #1 bus_ready = 1'b0;
        pulse(7);
        wait_rel;
        chk(16'(n >= 250 && n <= 262), 16'h0001);
        m = 32'h0380;
        rdm;
        chk(16'(irq_n), 16'h0000);
        host.put(1'b0, 16'h0080);
        m = 32'h0000;
        rdm;
        host.put(1'b0, 16'h0200);
        pulse(2);
        pulse(0);
        m = 32'h4000;
        rdm;
        chk(16'(irq_n), 16'h0001);
        $display("timeout and power-off test done");
        end_sim;
    end
endmodule
`default_nettype wire
